// *** rtl/tdmsd_regs.svh ***
// Register offsets, reset values and field positions of the slot drive and prefix block
`ifndef TDMSD_REGS_SVH
`define TDMSD_REGS_SVH
// Word indices (printed offsets); byte address is four times the index
`define TDMSD_IDX_CTRL        16'hd040
`define TDMSD_IDX_SLOT_SET    16'hd042
`define TDMSD_IDX_SLOT_CLR    16'hd043
`define TDMSD_IDX_SLOT_READ   16'hd044
`define TDMSD_IDX_DCHANNEL_READY_INPUT        16'hd045
`define TDMSD_IDX_PREFIX      16'hd046
`define TDMSD_IDX_BUF0        16'hd050
`define TDMSD_IDX_BUF1        16'hd051
`define TDMSD_IDX_BUF_ADDR    16'hd052
`define TDMSD_IDX_BUF_WDATA   16'hd053
// Reset values
`define TDMSD_RST_PREFIX      8'he0
`define TDMSD_RST_SLOT        16'h0000
`define TDMSD_RST_RATE        2'b10
// Field positions
`define TDMSD_CTRL_RATE_LSB   0
`define TDMSD_PREFIX_LSB      8
// Frame geometry
`define TDMSD_SLOT_BITS       8
`define TDMSD_DCH_SLOT        3
`define TDMSD_DCH_BIT         4
`define TDMSD_DCHANNEL_READY_INPUT_CHANNELS   8
`define TDMSD_BUF_DEPTH       64
`endif

// *** rtl/tdmsd_pkg.sv ***
// Types shared by the slot drive and prefix block
package tdmsd_pkg;
  typedef enum logic [1:0] {
    TDMSD_RATE_6  = 2'b00,
    TDMSD_RATE_12 = 2'b01,
    TDMSD_RATE_32 = 2'b10,
    TDMSD_RATE_64 = 2'b11
  } tdmsd_rate_t;
endpackage : tdmsd_pkg

// *** rtl/tdmsd_sync.sv ***
// Two flip-flop level synchroniser, one per bit
module tdmsd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : tdmsd_sync

// *** rtl/tdmsd_slot_map.sv ***
// Maps the rate mode and slot index onto the two output drive enables
`include "tdmsd_regs.svh"
module tdmsd_slot_map (
  input  wire logic [1:0]  rate_i,
  input  wire logic [15:0] slot_drive_enable_i,
  input  wire logic [7:0]  slot_i,
  output logic             drive0_o,
  output logic             drive1_o
);
  always_comb begin
    drive0_o = 1'b0;
    drive1_o = 1'b0;
    unique case (tdmsd_pkg::tdmsd_rate_t'(rate_i))
      tdmsd_pkg::TDMSD_RATE_6: begin
        if (slot_i < 8'd6) begin
          drive0_o = slot_drive_enable_i[slot_i[3:0]];
        end
      end
      tdmsd_pkg::TDMSD_RATE_12: begin
        if (slot_i < 8'd12) begin
          drive0_o = slot_drive_enable_i[slot_i[3:0]];
        end
      end
      tdmsd_pkg::TDMSD_RATE_32: begin
        if (slot_i < 8'd32) begin
          drive0_o = slot_drive_enable_i[{1'b0, slot_i[4:2]}];
          drive1_o = slot_drive_enable_i[{1'b1, slot_i[4:2]}];
        end
      end
      tdmsd_pkg::TDMSD_RATE_64: begin
        if (slot_i < 8'd64) begin
          drive0_o = slot_drive_enable_i[slot_i[5:2]];
        end
      end
    endcase
  end
endmodule : tdmsd_slot_map

// *** rtl/tdmsd_top.sv ***
// Slot drive control, D-channel ready sampling and read prefix of the serial frame unit
// What this block does
// - Enable bit 0 tri-states, 1 drives output
// - Six-slot mode: bits 0-5 map slots one-to-one
// - Twelve-slot mode: bits 0-11 map slots directly
// - Dual 32-slot: bits 0-7 out0, 8-15 out1
// - 64-slot mode: bit n drives slots 4n..4n+3
// - Ready samples show previous frame: 0 blocked
// - Sample bit k during channel k D-channel
// - Sixteen-channel mode samples first eight channels only
// - Buffer read returns prefix high, data low
// - Prefix byte resets to E0
// - Unused prefix register bits read zero
// - Rate field selects slot-group mapping, default 10
`include "tdmsd_regs.svh"
module tdmsd_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [17:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial link
  input  wire logic        link_clk_i,
  input  wire logic        link_rst_i,
  input  wire logic        frame_sync_i,
  input  wire logic        serial_data_0_i,
  input  wire logic        serial_data_1_i,
  input  wire logic        dchannel_ready_input_i,
  output logic             serial_data_out_0_o,
  output logic             serial_data_out_0_oe_o,
  output logic             serial_data_out_1_o,
  output logic             serial_data_out_1_oe_o
);
  // ----------------------------------------------------------------
  // Bus side registers
  // ----------------------------------------------------------------
  logic [15:0] slot_drive_control;
  logic [1:0]  serial_rate_select;
  logic [7:0]  read_prefix_byte;
  logic [7:0]  buf_waddr;
  logic [7:0]  frame_buf0 [`TDMSD_BUF_DEPTH];
  logic [7:0]  frame_buf1 [`TDMSD_BUF_DEPTH];
  logic [7:0]  dchannel_ready_samples;
  logic [15:0] idx;
  logic        req;
  logic        wr;
  logic        lo_en;
  logic        hi_en;
  logic        hit_ctrl;
  logic        hit_slot_set;
  logic        hit_slot_clr;
  logic        hit_slot_read;
  logic        hit_dchannel_ready_input;
  logic        hit_prefix;
  logic        hit_buf0;
  logic        hit_buf1;
  logic        hit_buf_addr;
  logic        hit_buf_wdata;
  logic [15:0] byte_mask;
  logic [31:0] next_rdata;

  assign idx   = wb_adr_i[17:2];
  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr    = req & wb_we_i;
  assign lo_en = wb_sel_i[0];
  assign hi_en = wb_sel_i[1];

  assign byte_mask = {{8{hi_en}}, {8{lo_en}}};

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // One decoder feeds both paths, so a write and a read of an index always agree
  assign hit_ctrl      = idx == `TDMSD_IDX_CTRL;
  assign hit_slot_set  = idx == `TDMSD_IDX_SLOT_SET;
  assign hit_slot_clr  = idx == `TDMSD_IDX_SLOT_CLR;
  assign hit_slot_read = idx == `TDMSD_IDX_SLOT_READ;
  assign hit_dchannel_ready_input      = idx == `TDMSD_IDX_DCHANNEL_READY_INPUT;
  assign hit_prefix    = idx == `TDMSD_IDX_PREFIX;
  assign hit_buf0      = idx == `TDMSD_IDX_BUF0;
  assign hit_buf1      = idx == `TDMSD_IDX_BUF1;
  assign hit_buf_addr  = idx == `TDMSD_IDX_BUF_ADDR;
  assign hit_buf_wdata = idx == `TDMSD_IDX_BUF_WDATA;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait state; a request still held while ack stands is not taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_drive_control <= `TDMSD_RST_SLOT;
    end else if (wr && hit_slot_set) begin
      slot_drive_control <= slot_drive_control | (wb_dat_i[15:0] & byte_mask);
    end else if (wr && hit_slot_clr) begin
      slot_drive_control <= slot_drive_control & ~(wb_dat_i[15:0] & byte_mask);
    end else if (wr && hit_slot_read) begin
      if (lo_en) slot_drive_control[7:0]  <= wb_dat_i[7:0];
      if (hi_en) slot_drive_control[15:8] <= wb_dat_i[15:8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_rate_select <= `TDMSD_RST_RATE;
    end else if (wr && hit_ctrl && lo_en) begin
      serial_rate_select <= wb_dat_i[`TDMSD_CTRL_RATE_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_prefix_byte <= `TDMSD_RST_PREFIX;
    end else if (wr && hit_prefix && hi_en) begin
      read_prefix_byte <= wb_dat_i[`TDMSD_PREFIX_LSB +: 8];
    end
  end

  // Buffer fill port stands in for the frame engine, which is outside this block
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_waddr <= 8'h00;
    end else if (wr && hit_buf_addr && lo_en) begin
      buf_waddr <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr && hit_buf_wdata && lo_en) begin
      if (buf_waddr[7]) frame_buf1[buf_waddr[5:0]] <= wb_dat_i[7:0];
      else              frame_buf0[buf_waddr[5:0]] <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped indices read zero; the buffer entry index rides on the write data lines
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (1'b1)
      hit_ctrl:      next_rdata[1:0]  = serial_rate_select;
      hit_slot_read: next_rdata[15:0] = slot_drive_control;
      hit_dchannel_ready_input:      next_rdata[7:0]  = dchannel_ready_samples;
      hit_prefix:    next_rdata[15:8] = read_prefix_byte;
      hit_buf0:      next_rdata[15:0] = {read_prefix_byte, frame_buf0[wb_dat_i[5:0]]};
      hit_buf1:      next_rdata[15:0] = {read_prefix_byte, frame_buf1[wb_dat_i[5:0]]};
      default:       next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data is registered and held until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Crossings into the link domain
  // ----------------------------------------------------------------
  // Quasi-static settings: software changes them only while the link idles,
  // so a per-bit two-stage sync is enough; a mid-frame change may mix one slot.
  logic [15:0] lk_slot_en;
  logic [1:0]  lk_rate;
  logic [3:0]  lk_in;

  tdmsd_sync #(
    .WIDTH (18)
  ) u_cfg_sync (
    .clk_i (link_clk_i),
    .rst_i (link_rst_i),
    .d_i   ({serial_rate_select, slot_drive_control}),
    .q_o   ({lk_rate, lk_slot_en})
  );

  tdmsd_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .clk_i (link_clk_i),
    .rst_i (link_rst_i),
    .d_i   ({serial_data_1_i, frame_sync_i, dchannel_ready_input_i, serial_data_0_i}),
    .q_o   (lk_in)
  );

  // ----------------------------------------------------------------
  // Link domain: bit and slot counting
  // ----------------------------------------------------------------
  logic       lk_fs_d;
  logic       lk_fs_rise;
  logic [2:0] bit_cnt;
  logic [7:0] slot_cnt;
  logic       lk_drive0;
  logic       lk_drive1;
  logic [7:0] dch_shadow;
  logic [7:0] dch_frame;
  logic       dch_toggle;

  assign lk_fs_rise = lk_in[2] & ~lk_fs_d;

  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      lk_fs_d  <= 1'b0;
      bit_cnt  <= 3'd0;
      slot_cnt <= 8'd0;
    end else begin
      lk_fs_d <= lk_in[2];
      if (lk_fs_rise) begin
        bit_cnt  <= 3'd1;
        slot_cnt <= 8'd0;
      end else begin
        bit_cnt <= bit_cnt + 3'd1;
        if (bit_cnt == 3'd7) begin
          slot_cnt <= slot_cnt + 8'd1;
        end
      end
    end
  end

  tdmsd_slot_map u_slot_map (
    .rate_i              (lk_rate),
    .slot_drive_enable_i (lk_slot_en),
    .slot_i              (slot_cnt),
    .drive0_o            (lk_drive0),
    .drive1_o            (lk_drive1)
  );

  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------
  // Outputs loop received data back; the frame engine data path lies outside
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      serial_data_out_0_o    <= 1'b1;
      serial_data_out_1_o    <= 1'b1;
      serial_data_out_0_oe_o <= 1'b0;
      serial_data_out_1_oe_o <= 1'b0;
    end else begin
      serial_data_out_0_o    <= lk_in[0];
      serial_data_out_1_o    <= lk_in[3];
      serial_data_out_0_oe_o <= lk_drive0;
      serial_data_out_1_oe_o <= lk_drive1;
    end
  end

  // ----------------------------------------------------------------
  // D-channel ready sampling
  // ----------------------------------------------------------------
  // Channel k owns slot 4k+3 and its bit 1 (the second bit) carries the ready level; only
  // eight channels are kept, so slots from 32 on are never sampled.
  for (genvar k = 0; k < `TDMSD_DCHANNEL_READY_INPUT_CHANNELS; k++) begin : g_dch
    logic hit;

    assign hit = slot_cnt == 8'(4 * k + `TDMSD_DCH_SLOT) && bit_cnt == 3'd1;

    always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
        dch_shadow[k] <= 1'b0;
      end else if (hit) begin
        dch_shadow[k] <= lk_in[1];
      end
    end
  end

  // The whole set moves at once, so a read never mixes two frames
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      dch_frame  <= 8'h00;
      dch_toggle <= 1'b0;
    end else if (lk_fs_rise) begin
      dch_frame  <= dch_shadow;
      dch_toggle <= ~dch_toggle;
    end
  end

  // ----------------------------------------------------------------
  // Frame snapshot handed to the bus domain by toggle
  // ----------------------------------------------------------------
  logic [2:0] tog_sync;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tog_sync               <= 3'b000;
      dchannel_ready_samples <= 8'h00;
    end else begin
      tog_sync <= {tog_sync[1:0], dch_toggle};
      if (tog_sync[2] != tog_sync[1]) begin
        dchannel_ready_samples <= dch_frame;
      end
    end
  end
endmodule : tdmsd_top

// *** tb/tdmsd_assertions.sv ***
// Bus and link checker for the slot drive and prefix block
`include "tdmsd_regs.svh"
module tdmsd_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        link_clk_i,
  input wire logic        link_rst_i,
  input wire logic        serial_data_out_0_oe_o,
  input wire logic        serial_data_out_1_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  pfx;
  logic [1:0]  rate;
  logic [15:0] slot;
  logic [15:0] idx;
  logic        wr;
  logic        rd;
  assign idx = wb_adr_i[17:2];
  assign wr  = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
  assign rd  = wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i;
  // Shadows follow writes at the ack edge, one clock after the edge where the registers take them
  always_ff @(posedge clk_i)
    if (rst_i) pfx <= 8'he0;
    else if (wr && idx == `TDMSD_IDX_PREFIX) pfx <= wb_dat_i[15:8];
  always_ff @(posedge clk_i)
    if (rst_i) rate <= 2'h2;
    else if (wr && idx == `TDMSD_IDX_CTRL) rate <= wb_dat_i[1:0];
  always_ff @(posedge clk_i)
    if (rst_i) slot <= 16'h0000;
    else if (wr && idx == `TDMSD_IDX_SLOT_SET) slot <= slot | wb_dat_i[15:0];
    else if (wr && idx == `TDMSD_IDX_SLOT_CLR) slot <= slot & ~wb_dat_i[15:0];
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i) req_s |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  prefix_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == `TDMSD_IDX_PREFIX |-> wb_dat_o == {16'h0000, pfx, 8'h00})
    else $error("prefix register read wrong");
  dchannel_ready_input_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == `TDMSD_IDX_DCHANNEL_READY_INPUT |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("ready sample upper bits not zero");
  buf_prefix_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && (idx == `TDMSD_IDX_BUF0 || idx == `TDMSD_IDX_BUF1)
    |-> wb_dat_o[31:8] == {16'h0000, pfx}) else $error("buffer read high byte wrong");
  out1_quiet_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    rate != 2'h2 |-> !serial_data_out_1_oe_o) else $error("output 1 driven outside dual mode");
  all_tristate_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    slot == 16'h0000 |-> !serial_data_out_0_oe_o && !serial_data_out_1_oe_o)
    else $error("output driven with all enables clear");
endmodule : tdmsd_assertions
bind tdmsd_top tdmsd_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_clk_i(link_clk_i), .link_rst_i(link_rst_i),
  .serial_data_out_0_oe_o(serial_data_out_0_oe_o),
  .serial_data_out_1_oe_o(serial_data_out_1_oe_o));

// *** tb/tdmsd_link_model.sv ***
// Line transceiver model: frame sync, data and D-channel ready per slot
module tdmsd_link_model (
  input  wire logic       link_clk_i,
  input  wire logic       link_rst_i,
  input  wire logic [1:0] rate_i,
  input  wire logic [7:0] ready_pattern_i,
  output logic            frame_sync_o,
  output logic            serial_data_o,
  output logic            ready_o,
  output logic [5:0]      slot_o,
  output logic [2:0]      bit_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] pat;
  logic [6:0] nslots;
  logic [3:0] ch;
  assign nslots = rate_i == 2'h0 ? 7'h06 : rate_i == 2'h1 ? 7'h0c : rate_i == 2'h2 ? 7'h20 : 7'h40;
  assign ch = slot_o[5:2];
  always_ff @(posedge link_clk_i)
    if (link_rst_i) begin
      slot_o <= 6'h00;
      bit_o  <= 3'h0;
    end else begin
      bit_o <= bit_o + 3'h1;
      if (bit_o == 3'h7) slot_o <= ({1'b0, slot_o} == nslots - 7'h01) ? 6'h00 : slot_o + 6'h01;
    end
  // Pattern is taken once per frame so a whole frame offers one set
  always_ff @(posedge link_clk_i)
    if (link_rst_i || (slot_o == 6'h00 && bit_o == 3'h0)) pat <= ready_pattern_i;
  assign frame_sync_o  = slot_o == 6'h00 && !link_rst_i;
  assign serial_data_o = bit_o[0] ^ slot_o[0];
  // Outside the sampled slots the line carries the inverse, so a stray sample shows
  assign ready_o = (slot_o[1:0] == 2'h3 && !ch[3]) ? pat[ch[2:0]] : ~pat[ch[2:0]];
endmodule : tdmsd_link_model

// *** tb/test_tdmsd_top.sv ***
// Self-checking bench for the slot drive and prefix block
`include "tdmsd_regs.svh"
module test_tdmsd_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, lclk = 0, lrst = 1;
  logic [17:0] adr = 18'h0_0000;
  logic [31:0] dw = 32'h0000_0000, dr;
  logic ack, fs, sd0, rdy, o0, oe0, o1, oe1;
  logic [1:0] rate = 2'h2;
  logic [7:0] pat = 8'h00;
  logic [5:0] slot;
  logic [2:0] bitn;
  logic [63:0] cap0, cap1, capd0, capd1;
  logic [31:0] q;
  int errors = 0, total_checks = 0;
  tdmsd_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .link_clk_i(lclk), .link_rst_i(lrst), .frame_sync_i(fs), .serial_data_0_i(sd0),
    .serial_data_1_i(sd0), .dchannel_ready_input_i(rdy), .serial_data_out_0_o(o0),
    .serial_data_out_0_oe_o(oe0), .serial_data_out_1_o(o1), .serial_data_out_1_oe_o(oe1));
  tdmsd_link_model u_link (.link_clk_i(lclk), .link_rst_i(lrst), .rate_i(rate),
    .ready_pattern_i(pat), .frame_sync_o(fs), .serial_data_o(sd0), .ready_o(rdy),
    .slot_o(slot), .bit_o(bitn));
  initial forever #5 clk_i = ~clk_i;
  initial begin
    #3;
    forever #15 lclk = ~lclk;
  end
  // Mid-slot sampling leaves room for the design's sync lag
  always @(posedge lclk) if (bitn == 3'h6) begin
    cap0[slot] <= oe0;
    cap1[slot] <= oe1;
    capd0[slot] <= o0;
    capd1[slot] <= o1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_map(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_map
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we  <= w;
    adr <= {idx, 2'b00};
    dw  <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dr;
    if (n >= 20) errors++;
    cyc <= 0;
    stb <= 0;
    we  <= 0;
    @(posedge clk_i);
  endtask : bus
  function automatic logic [63:0] exp_map(input logic [1:0] r, input logic [15:0] en,
                                          input logic p1);
    logic [63:0] m;
    for (int s = 0; s < 64; s++)
      if (r == 2'h0) m[s] = !p1 && s < 6 && en[s%16];
      else if (r == 2'h1) m[s] = !p1 && s < 12 && en[s%16];
      else if (r == 2'h2) m[s] = s < 32 && en[s/4 + (p1 ? 8 : 0)];
      else m[s] = !p1 && en[s/4];
    return m;
  endfunction : exp_map
  // Loopback data trails the line by three link clocks: mid-slot shows bit 3,
  // which the model sends as the inverse of the slot's low bit
  function automatic logic [63:0] exp_data(input logic [1:0] r);
    logic [63:0] m;
    for (int s = 0; s < 64; s++)
      m[s] = s < (r == 2'h0 ? 6 : r == 2'h1 ? 12 : r == 2'h2 ? 32 : 64) && s % 2 == 0;
    return m;
  endfunction : exp_data
  task automatic run_mode(input logic [1:0] r, input logic [15:0] en, input logic [7:0] p);
    @(posedge lclk);
    lrst <= 1;
    rate <= r;
    pat  <= p;
    @(posedge clk_i);
    // Configuration only changes while the link is held idle
    bus(1, `TDMSD_IDX_CTRL, {30'h0, r});
    bus(1, `TDMSD_IDX_SLOT_CLR, 32'h0000_ffff);
    bus(1, `TDMSD_IDX_SLOT_SET, {16'h0000, en});
    bus(0, `TDMSD_IDX_SLOT_READ, 32'h0000_0000);
    chk(q, {16'h0000, en});
    repeat (6) @(posedge lclk);
    lrst <= 0;
    repeat (2) @(posedge fs);
    cap0 = 64'h0;
    cap1 = 64'h0;
    capd0 = 64'h0;
    capd1 = 64'h0;
    @(posedge fs);
    @(posedge clk_i);
    chk_map(cap0, exp_map(r, en, 1'b0));
    chk_map(cap1, exp_map(r, en, 1'b1));
    chk_map(capd0, exp_data(r));
    chk_map(capd1, exp_data(r));
    if (r[1]) begin
      bus(0, `TDMSD_IDX_DCHANNEL_READY_INPUT, 32'h0000_0000);
      chk(q, {24'h00_0000, p});
    end
  endtask : run_mode
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  // --------------------------------
  // Scenarios
  // --------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    bus(0, `TDMSD_IDX_PREFIX, 32'h0000_0000);
    chk(q, 32'h0000_e000);
    bus(0, `TDMSD_IDX_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0002);
    bus(0, 16'hd047, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1, `TDMSD_IDX_BUF_ADDR, 32'h0000_0005);
    bus(1, `TDMSD_IDX_BUF_WDATA, 32'h0000_003c);
    bus(1, `TDMSD_IDX_BUF_ADDR, 32'h0000_0087);
    bus(1, `TDMSD_IDX_BUF_WDATA, 32'h0000_005a);
    bus(0, `TDMSD_IDX_BUF0, 32'h0000_0005);
    chk(q, 32'h0000_e03c);
    bus(1, `TDMSD_IDX_PREFIX, 32'hffff_12ff);
    bus(0, `TDMSD_IDX_PREFIX, 32'h0000_0000);
    chk(q, 32'h0000_1200);
    bus(0, `TDMSD_IDX_BUF1, 32'h0000_0007);
    chk(q, 32'h0000_125a);
    run_mode(2'h0, 16'hffe5, 8'h00);
    run_mode(2'h1, 16'hf6a3, 8'h00);
    run_mode(2'h2, 16'h5ac3, 8'h96);
    run_mode(2'h3, 16'h3c69, 8'h5a);
    run_mode(2'h2, 16'h0000, 8'hc3);
    report_and_stop;
  end
  initial begin
    #300_000;
    errors++;
    report_and_stop;
  end
endmodule : test_tdmsd_top
